// file: verilog/viu_pkg.sv
// package: constants for the vectored interrupt unit
package viu_pkg;
   // ===================== register map (byte addresses)
   localparam logic [3:0] VIU_OFS_FLAG = 4'h0; // irq_flag_reg
   localparam logic [3:0] VIU_OFS_MASK = 4'h4; // irq_mask_reg
   localparam logic [3:0] VIU_OFS_CTRL = 4'h8; // global enable / busy status
   localparam logic [3:0] VIU_OFS_STAT = 4'hC; // pending status (flags and-ed with mask)
   localparam logic [3:0] VIU_OFS_IEN = 4'h0; // alias note: int enable reg below
   localparam logic [3:0] VIU_OFS_ISTS = 4'h0; // unused alias, kept zero
   // ===================== reset values
   localparam logic [7:0] VIU_FLAG_RST = 8'h00;
   localparam logic [7:0] VIU_MASK_RST = 8'h00;
   localparam logic [7:0] VIU_DATA_RST = 8'h00;
   // ===================== field positions
   localparam int VIU_CTRL_GIE_BIT = 0;
   localparam int VIU_CTRL_BUSY_BIT = 1;
   localparam int VIU_SRC_PORTCHG = 7;
   localparam int VIU_NSRC = 8;
   // ===================== vectors
   localparam logic [11:0] VIU_VEC_BASE = 12'h003;
   localparam logic [11:0] VIU_VEC_STEP = 12'h003;
   // ===================== bus responses
   localparam logic [1:0] VIU_RESP_OKAY = 2'h0;
   localparam logic [1:0] VIU_RESP_SLVERR = 2'h2;
   // ===================== service state
   typedef enum logic [1:0] {
      VIU_IDLE = 2'b00,
      VIU_ENTER = 2'b01,
      VIU_SERVE = 2'b10
   } viu_state_t;
endpackage

// file: verilog/viu_top.sv
// vectored interrupt unit: flags, mask, dispatch, context save and restore
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
module viu_top (
   // clock, reset, enable
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // request sources
   input wire logic i_tick_ovf,
   input wire logic [7:0] i_port5,
   input wire logic [3:0] i_cnt_uf,
   input wire logic i_port_chg,
   // core sequencing
   input wire logic i_global_irq_on_instr,
   input wire logic i_global_irq_off_instr,
   input wire logic i_ret_from_isr,
   input wire logic i_fetch_ack,
   input wire logic [7:0] i_working_register,
   input wire logic [7:0] i_status_flags_reg,
   output logic o_vec_req,
   output logic [11:0] o_vec_addr,
   output logic o_restore,
   output logic [7:0] o_working_register,
   output logic [7:0] o_status_flags_reg,
   output logic o_wake,
   output logic o_irq,
   // axi4-lite slave
   input wire logic [3:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [3:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   import viu_pkg::*;

   // lowest-index pending source; lowest vector first
   function automatic logic [2:0] pick_low(input logic [7:0] p);
      logic [2:0] r;
      r = 3'h0;
      for (int k = 7; k >= 0; k--) begin
         if (p[k]) r = 3'(k);
      end
      return r;
   endfunction

   // ==========================================================================
   // source synchronisers and edge detect
   logic [7:0] raw_src, sync1, sync2, sync3, fall;
   assign raw_src = {i_port_chg, i_cnt_uf, i_port5[5], i_port5[4], i_tick_ovf};

   // two stages then a delay stage for edge detection
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         sync1 <= 8'hFF;
         sync2 <= 8'hFF;
         sync3 <= 8'hFF;
      end else if (i_ce) begin
         sync1 <= raw_src;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   assign fall = sync3 & ~sync2;

   // ==========================================================================
   // registers
   logic [7:0] irq_flag_reg, irq_mask_reg, int_mask, int_sts, save_wreg, save_sts;
   logic gie, busy;
   viu_state_t state;
   logic [2:0] cur_src;

   // bus write path
   logic aw_hold, w_hold, do_wr;
   logic [3:0] aw_addr, w_strb;
   logic [31:0] w_data;
   assign o_awready = !aw_hold && !o_bvalid;
   assign o_wready = !w_hold && !o_bvalid;
   assign do_wr = aw_hold && w_hold && !o_bvalid;

   // capture address and data in either order
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= VIU_RESP_OKAY;
      end else if (i_ce) begin
         if (i_awvalid && o_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_hold <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (do_wr) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= (aw_addr[3:2] == 2'h3) ? VIU_RESP_SLVERR : VIU_RESP_OKAY;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   logic wr_flag, wr_mask, wr_ctrl, wr_ie, wr_is;
   assign wr_flag = do_wr && w_strb[0] && aw_addr == VIU_OFS_FLAG;
   assign wr_mask = do_wr && w_strb[0] && aw_addr == VIU_OFS_MASK;
   assign wr_ctrl = do_wr && w_strb[0] && aw_addr == VIU_OFS_CTRL;
   assign wr_ie = do_wr && w_strb[1] && aw_addr == VIU_OFS_MASK;
   assign wr_is = do_wr && w_strb[1] && aw_addr == VIU_OFS_FLAG;

   // mask registers
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         irq_mask_reg <= VIU_MASK_RST;
         int_mask <= VIU_MASK_RST;
      end else if (i_ce) begin
         if (wr_mask) irq_mask_reg <= w_data[7:0];
         if (wr_ie) int_mask <= w_data[15:8];
      end
   end

   // flags: set wins over a software clear
   logic [7:0] set_ev;
   assign set_ev = fall & irq_mask_reg;
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         irq_flag_reg <= VIU_FLAG_RST;
      end else if (i_ce) begin
         if (wr_flag) begin
            irq_flag_reg <= (irq_flag_reg & w_data[7:0]) | set_ev;
         end else begin
            irq_flag_reg <= irq_flag_reg | set_ev;
         end
      end
   end

   // wake on port change regardless of its mask bit
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_wake <= 1'b0;
      end else if (i_ce) begin
         o_wake <= fall[VIU_SRC_PORTCHG] | (|set_ev);
      end
   end

   // global enable
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         gie <= 1'b0;
      end else if (i_ce) begin
         if (i_global_irq_on_instr) begin
            gie <= 1'b1;
         end else if (i_global_irq_off_instr) begin
            gie <= 1'b0;
         end else if (wr_ctrl) begin
            gie <= w_data[VIU_CTRL_GIE_BIT];
         end
      end
   end

   // ==========================================================================
   // dispatch and context
   logic [7:0] pend;
   assign pend = irq_flag_reg & irq_mask_reg;
   assign busy = state != VIU_IDLE;

   // service sequencer
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         state <= VIU_IDLE;
         cur_src <= 3'h0;
         save_wreg <= VIU_DATA_RST;
         save_sts <= VIU_DATA_RST;
         o_restore <= 1'b0;
         o_working_register <= VIU_DATA_RST;
         o_status_flags_reg <= VIU_DATA_RST;
         o_vec_addr <= 12'h000;
      end else if (i_ce) begin
         o_restore <= 1'b0;
         unique case (state)
            VIU_IDLE: begin
               if (gie && |pend) begin
                  cur_src <= pick_low(pend);
                  o_vec_addr <= VIU_VEC_BASE
                     + VIU_VEC_STEP * {9'h000, pick_low(pend)};
                  save_wreg <= i_working_register;
                  save_sts <= i_status_flags_reg;
                  state <= VIU_ENTER;
               end
            end
            VIU_ENTER: begin
               if (i_fetch_ack) begin
                  state <= VIU_SERVE;
               end
            end
            VIU_SERVE: begin
               if (i_ret_from_isr) begin
                  o_working_register <= save_wreg;
                  o_status_flags_reg <= save_sts;
                  o_restore <= 1'b1;
                  state <= VIU_IDLE;
               end
            end
            default: begin
               state <= VIU_IDLE;
            end
         endcase
      end
   end
   assign o_vec_req = state == VIU_ENTER;

   // interrupt status: sticky events, write one to clear
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         int_sts <= VIU_FLAG_RST;
      end else if (i_ce) begin
         if (wr_is) begin
            int_sts <= (int_sts & ~w_data[15:8]) | set_ev;
         end else begin
            int_sts <= int_sts | set_ev;
         end
      end
   end
   assign o_irq = |(int_sts & int_mask);

   // ==========================================================================
   // read channel
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_araddr[3:2])
         2'h0: rd_mux = {16'h0000, int_sts, irq_flag_reg};
         2'h1: rd_mux = {16'h0000, int_mask, irq_mask_reg};
         2'h2: rd_mux = {30'h0000_0000, busy, gie};
         2'h3: rd_mux = {24'h00_0000, pend};
      endcase
   end
   assign o_arready = !o_rvalid;

   // single-cycle read answer
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= VIU_RESP_OKAY;
      end else if (i_ce) begin
         if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_mux;
            o_rresp <= VIU_RESP_OKAY;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // assertions
   property p_no_nest;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (state == VIU_SERVE && !i_ret_from_isr && i_ce) |=> state == VIU_SERVE;
   endproperty
   a_no_nest: assert property (p_no_nest) else $error("nested dispatch");
   property p_vec_range;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_vec_req |-> (o_vec_addr >= 12'h003 && o_vec_addr <= 12'h018);
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector out of range");
   property p_vec_map;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_vec_req |-> o_vec_addr == 12'h003 + 12'h003 * {9'h000, cur_src};
   endproperty
   a_vec_map: assert property (p_vec_map) else $error("vector mismatch");
   property p_flag_set;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_ce && set_ev[1]) |=> irq_flag_reg[1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");
   property p_gie_gate;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (state == VIU_IDLE && !gie) |=> state == VIU_IDLE;
   endproperty
   a_gie_gate: assert property (p_gie_gate) else $error("dispatch while disabled");
   property p_prio;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_ce && state == VIU_IDLE && gie && pend[0]) |=> cur_src == 3'h0;
   endproperty
   a_prio: assert property (p_prio) else $error("priority wrong");
   // the return must raise the pulse and hand back what was saved at dispatch
   property p_restore;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_ce && state == VIU_SERVE && i_ret_from_isr) |=> (o_restore
         && o_working_register == $past(save_wreg) && o_status_flags_reg == $past(save_sts));
   endproperty
   a_restore: assert property (p_restore) else $error("restore mismatch");
   property p_save;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_ce && state == VIU_IDLE && gie && |pend) |=> save_wreg == $past(i_working_register);
   endproperty
   a_save: assert property (p_save) else $error("save missing");
endmodule
`default_nettype wire

// file: tb/viu_core_model.sv
// core model: takes vectors, runs a routine, returns on command
`timescale 1ns/100ps
`default_nettype none
module viu_core_model (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // from unit and bench
   input wire logic i_vec_req,
   input wire logic i_ret_go,
   input wire logic [3:0] i_ack_dly,
   input wire logic [7:0] i_wreg,
   input wire logic [7:0] i_sr,
   // to unit and bench
   output logic o_fetch_ack,
   output logic o_ret,
   output logic o_in_svc,
   output logic [7:0] o_wreg,
   output logic [7:0] o_sr
);
   logic [3:0] cnt;
   // ack after a chosen delay, return only while serving
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_fetch_ack <= 1'b0;
         o_ret <= 1'b0;
         o_in_svc <= 1'b0;
         cnt <= 4'h0;
      end else begin
         o_ret <= 1'b0;
         if (i_vec_req && !o_fetch_ack && !o_in_svc) begin
            if (cnt >= i_ack_dly) begin
               o_fetch_ack <= 1'b1;
               cnt <= 4'h0;
            end else begin
               cnt <= cnt + 4'h1;
            end
         end else begin
            o_fetch_ack <= 1'b0;
         end
         if (o_fetch_ack && i_vec_req) begin
            o_in_svc <= 1'b1;
         end
         if (o_in_svc && i_ret_go && !o_ret) begin
            o_ret <= 1'b1;
            o_in_svc <= 1'b0;
         end
      end
   end
   // routine clobbers core state while it runs
   assign o_wreg = o_in_svc ? ~i_wreg : i_wreg;
   assign o_sr = o_in_svc ? ~i_sr : i_sr;
endmodule
`default_nettype wire

// file: tb/test_viu_top.sv
// testbench for the vectored interrupt unit
`timescale 1ns/100ps
`default_nettype none
module test_viu_top;
   import viu_pkg::*;
   logic clk, nrst, ce, ron, roff, ret, ack, ret_go, svc, awv, wv, bre, arv, rre;
   logic vreq, rst_o, wake, irq, awr, wr, bv, arr, rv;
   logic [7:0] src, t_wreg, t_sr, wreg, sr, wra, sra;
   logic [3:0] ack_dly, awa, ws, ara;
   logic [31:0] wd, rd;
   logic [11:0] va;
   logic [1:0] br, rr, br_q;
   logic [31:0] vq[$], rq[$];
   int err_total, samples_checked, wake_n;
   viu_top dut (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_tick_ovf(src[0]),
      .i_port5({2'b11, src[2], src[1], 4'hF}), .i_cnt_uf(src[6:3]), .i_port_chg(src[7]),
      .i_global_irq_on_instr(ron), .i_global_irq_off_instr(roff), .i_ret_from_isr(ret),
      .i_fetch_ack(ack), .i_working_register(wreg), .i_status_flags_reg(sr), .o_vec_req(vreq),
      .o_vec_addr(va), .o_restore(rst_o), .o_working_register(wra), .o_status_flags_reg(sra),
      .o_wake(wake), .o_irq(irq), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
      .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr), .o_bresp(br), .o_bvalid(bv),
      .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd),
      .o_rresp(rr), .o_rvalid(rv), .i_rready(rre));
   viu_core_model core (.i_ref_clk(clk), .i_nrst(nrst), .i_vec_req(vreq), .i_ret_go(ret_go),
      .i_ack_dly(ack_dly), .i_wreg(t_wreg), .i_sr(t_sr), .o_fetch_ack(ack), .o_ret(ret),
      .o_in_svc(svc), .o_wreg(wreg), .o_sr(sr));
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // axi4-lite write, channels released as each is taken
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      logic ah, wh, bh;
      n = 0;
      bh = 1'b0;
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (!bh && n < 200) begin
         @(negedge clk);
         ah = awv & awr;
         wh = wv & wr;
         bh = bre & bv;
         if (bh) br_q = br;
         @(posedge clk);
         if (ah) awv <= 1'b0;
         if (wh) wv <= 1'b0;
         if (bh) bre <= 1'b0;
         n++;
      end
      @(posedge clk); // idle edge so a following call never re-drives bready in this step
      if (!bh) begin
         err_total++;
         end_sim();
      end
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] d);
      int n;
      logic ah, rh;
      n = 0;
      rh = 1'b0;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      while (!rh && n < 200) begin
         @(negedge clk);
         ah = arv & arr;
         rh = rre & rv;
         if (rh) d = rd;
         @(posedge clk);
         if (ah) arv <= 1'b0;
         if (rh) rre <= 1'b0;
         n++;
      end
      @(posedge clk); // idle edge so a following call never re-drives rready in this step
      if (!rh) begin
         err_total++;
         end_sim();
      end
   endtask
   // one-cycle instruction pulse to the unit
   task automatic instr(input logic on);
      ron <= on;
      roff <= !on;
      @(posedge clk);
      ron <= 1'b0;
      roff <= 1'b0;
      @(posedge clk);
   endtask
   // falling edge on the sources set in m, then back high
   task automatic fall(input logic [7:0] m);
      src <= ~m;
      repeat (4) @(posedge clk);
      src <= 8'hFF;
      repeat (6) @(posedge clk);
   endtask
   task automatic wait_svc();
      int n;
      for (n = 0; n < 300 && svc !== 1'b1; n++) @(posedge clk);
      if (svc !== 1'b1) begin
         err_total++;
         end_sim();
      end
   endtask
   // routine body: clear own flag, then return
   task automatic serve(input int i);
      wait_svc();
      axw(VIU_OFS_FLAG, {24'h0, ~(8'h01 << i)}, 4'h1);
      ret_go <= 1'b1;
      @(posedge clk);
      ret_go <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic note(input int i);
      vq.push_back(32'(VIU_VEC_BASE + VIU_VEC_STEP * 12'(i)));
      rq.push_back({16'h0, t_wreg, t_sr});
   endtask
   // monitor: compare each dispatch and restore with the oldest note
   always @(posedge clk) begin
      if (nrst === 1'b1) begin
         if (vreq === 1'b1 && ack === 1'b1) begin
            check("vector", va, vq.size() ? vq.pop_front() : 32'hFFF);
         end
         if (rst_o === 1'b1) begin
            check("restore", {wra, sra}, rq.size() ? rq.pop_front() : 32'hFFFF);
         end
         if (wake === 1'b1) wake_n++;
      end
   end
   initial begin
      logic [31:0] d;
      int i, w;
      {nrst, ron, roff, ret_go, awv, wv, bre, arv, rre} = '0;
      {awa, ara, ws, wd, ack_dly, t_wreg, t_sr} = '0;
      src = 8'hFF;
      ce = 1'b1;
      void'($urandom(50));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 4; i++) begin
         axr(4'(i * 4), d);
         check("reset value", d, 32'h0);
      end
      axw(VIU_OFS_STAT, 32'hFF, 4'h1);
      check("ro write resp", 32'(br_q), 32'(VIU_RESP_SLVERR));
      $display("test reset and map done");
      axw(VIU_OFS_MASK, 32'hFF, 4'h1);
      instr(1'b1);
      axr(VIU_OFS_CTRL, d);
      check("global enable", d[VIU_CTRL_GIE_BIT], 1'b1);
      for (i = 0; i < VIU_NSRC; i++) begin
         t_wreg <= 8'($urandom);
         t_sr <= 8'($urandom);
         ack_dly <= 4'($urandom % 4);
         @(posedge clk);
         note(i);
         fall(8'h01 << i);
         serve(i);
      end
      $display("test each source done");
      axw(VIU_OFS_MASK, 32'hFB, 4'h1);
      fall(8'h04);
      axr(VIU_OFS_FLAG, d);
      check("masked flag", d[7:0], 8'h00);
      instr(1'b0);
      axw(VIU_OFS_MASK, 32'hFF, 4'h1);
      fall(8'h24);
      check("no dispatch gie off", vreq, 1'b0);
      axr(VIU_OFS_STAT, d);
      check("pending", d[7:0], 8'h24);
      note(2);
      note(0);
      note(5);
      instr(1'b1);
      wait_svc();
      axr(VIU_OFS_CTRL, d);
      check("busy in service", d[1:0], 2'h3);
      fall(8'h01);
      check("no nesting", vreq, 1'b0);
      serve(2);
      serve(0);
      serve(5);
      $display("test priority and pending done");
      instr(1'b0);
      axw(VIU_OFS_FLAG, 32'hFF00, 4'h2);
      axw(VIU_OFS_MASK, 32'h017F, 4'h3);
      axr(VIU_OFS_MASK, d);
      check("mask readback", d, 32'h017F);
      check("irq idle", irq, 1'b0);
      w = wake_n;
      fall(8'h80);
      check("wake count", 32'(wake_n), 32'(w + 1));
      axr(VIU_OFS_FLAG, d);
      check("no change flag", d[7], 1'b0);
      fall(8'h01);
      check("irq on", irq, 1'b1);
      axw(VIU_OFS_MASK, 32'h007F, 4'h3);
      check("irq masked", irq, 1'b0);
      axw(VIU_OFS_MASK, 32'h017F, 4'h3);
      check("irq sticky", irq, 1'b1);
      axw(VIU_OFS_FLAG, 32'h0100, 4'h3);
      check("irq cleared", irq, 1'b0);
      check("notes left", 32'(vq.size() + rq.size()), 32'h0);
      $display("test wake and irq done");
      ce <= 1'b0;
      fall(8'h02);
      ce <= 1'b1;
      @(posedge clk);
      axr(VIU_OFS_FLAG, d);
      check("frozen flag", d[7:0], 8'h00);
      axw(VIU_OFS_CTRL, 32'h1, 4'h1);
      axr(VIU_OFS_CTRL, d);
      check("bus enable", d[1:0], 2'h1);
      $display("test freeze and bus enable done");
      end_sim();
   end
endmodule
`default_nettype wire
